// ---- core/nim_io.sv ----
// Front-panel NIM I/O logic: event counters, pulse generator, coincidence inputs, defaults.
// Function
// RL1: Two event counters on inputs 1 and 3, each enabled independently.
// RL2: Each counter selects counting falling or rising transitions of its input.
// RL3: Input 2 clears counter 1 when its reset enable is set.
// RL4: Input 4 clears counter 2 when its reset enable is set.
// RL5: A software command clears each counter independently of the hardware inputs.
// RL6: Output 1 is a pulse generator with programmable period, width and polarity.
// RL7: Written period is rounded to nearest resolution step; stored value shows it.
// RL8: Each coincidence input has its own software reset that re-arms it.
// RL9: Each coincidence input's dead time count stays readable until it is reset.
// RL10: Default button reloads the stored default configuration into active settings.
// RL11: Defaults are stored only when the dedicated store command is written.
// RL12: Hardware reset comes from the reset button or an external switch.
// RL13: Pending mask: bit0 trigger1, bit1 trigger2, bit2 dead time1, bit3 dead time2.
// RL14: Each default button press raises its own interrupt event.
// RL15: Pins are synchronised before edge detection; each edge counts exactly one.
// RL16: Event counters wrap to zero after the maximum and keep counting.
`timescale 1ns/10ps
`include "nim_io_consts.svh"
module nim_io #(
   parameter int CNT_W = 32,
   parameter int DT_W = 32,
   parameter int PG_RES_SHIFT = 3
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // Register port.
   input wire logic [7:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rd_data,
   // Front-panel pins, asynchronous to ref_clk.
   input wire logic [3:0] nim_in,
   input wire logic [1:0] combo_in,
   input wire logic default_btn,
   input wire logic reset_btn,
   input wire logic reset_sw,
   // Outputs.
   output logic nim_out1,
   output logic irq,
   output logic hw_reset
);

   // Widths the read path and the rounding logic can serve; others stop elaboration.
   if (CNT_W < 1 || CNT_W > 32 || DT_W < 1 || DT_W > 32 ||
       PG_RES_SHIFT < 1 || PG_RES_SHIFT > 16) begin : g_param_check
      $error("nim_io: unsupported parameter value");
   end

   // Pin count, and the step mask and half step of the period resolution.
   localparam int PIN_W = 9;
   localparam logic [31:0] RES_MASK = 32'((64'h1 << PG_RES_SHIFT) - 64'h1);
   localparam logic [32:0] RES_HALF = 33'(64'h1 << (PG_RES_SHIFT - 1));

   // Picks the qualifying transition of a synchronised level.
   function automatic logic edge_hit(input logic prev, input logic cur, input logic rise);
      edge_hit = rise ? (cur & ~prev) : (prev & ~cur);
   endfunction

   // Synchroniser stages and the decoded pin views.
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] meta_reg;
   logic [PIN_W-1:0] sync_reg;
   logic [PIN_W-1:0] prev_reg;
   nim_io_pkg::pins_s pins;
   nim_io_pkg::pins_s pins_prev;
   // Active and stored default configuration.
   nim_io_pkg::cfg_s cfg_reg;
   nim_io_pkg::cfg_s def_reg;
   // Counters, coincidence state and interrupt state.
   logic [CNT_W-1:0] cnt1_reg;
   logic [CNT_W-1:0] cnt2_reg;
   logic [31:0] pg_cnt_reg;
   logic [1:0] armed_reg;
   logic [DT_W-1:0] dt_reg [2];
   logic [`NIM_IRQ_W-1:0] irq_stat_reg;
   logic [`NIM_IRQ_W-1:0] irq_mask_reg;
   logic [`NIM_IRQ_W-1:0] irq_set;
   logic [1:0] trig_hit;
   logic [1:0] dt_full;
   // Decoded strobes, the period rounding path and the generator gate.
   logic wr_cmd;
   logic defbtn_hit;
   logic [32:0] period_sum;
   logic [31:0] period_round;
   logic pg_active;

   // Pin bundle, command strobe and default button edge.
   assign pin_raw = {nim_in, combo_in, default_btn, reset_btn, reset_sw};
   assign pins = nim_io_pkg::pins_s'(sync_reg);
   assign pins_prev = nim_io_pkg::pins_s'(prev_reg);
   assign wr_cmd = wr_en && (addr == `NIM_OFS_CMD);
   assign defbtn_hit = pins.default_btn & ~pins_prev.default_btn;

   // Two-stage synchroniser per pin; only the second stage and its delayed copy feed logic.
   // All stages reset to the idle low level, so no false edge follows reset.
   genvar gi;
   generate
      for (gi = 0; gi < PIN_W; gi++) begin : g_sync
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               meta_reg[gi] <= 1'b0;
               sync_reg[gi] <= 1'b0;
               prev_reg[gi] <= 1'b0;
            end else begin
               meta_reg[gi] <= pin_raw[gi]; // RL15
               sync_reg[gi] <= meta_reg[gi]; // RL15
               prev_reg[gi] <= sync_reg[gi];
            end
         end
      end
   endgenerate

   // Hardware reset request follows either the button or the external switch.
   // It is only a request: the board's supervisor acts on it, this block keeps running.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         hw_reset <= 1'b0;
      end else begin
         hw_reset <= pins.reset_btn | pins.reset_sw; // RL12
      end
   end

   // Period rounding to the nearest resolution step, saturating at the top step.
   // Saturation keeps a huge request from wrapping round to a tiny period.
   always_comb begin
      period_sum = {1'b0, wr_data} + RES_HALF;
      if (period_sum[32]) begin
         period_round = ~RES_MASK;
      end else begin
         period_round = period_sum[31:0] & ~RES_MASK; // RL7
      end
   end

   // Active configuration: software writes, or a button press recalls the defaults.
   // The button wins over a write in the same cycle, since it is the operator's action.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cfg_reg.ctrl <= `NIM_RST_CTRL;
         cfg_reg.period <= `NIM_RST_PERIOD;
         cfg_reg.width <= `NIM_RST_WIDTH;
      end else if (defbtn_hit) begin
         cfg_reg <= def_reg; // RL10
      end else if (wr_en) begin
         if (addr == `NIM_OFS_CTRL) begin
            cfg_reg.ctrl <= wr_data[7:0];
         end
         if (addr == `NIM_OFS_PERIOD) begin
            cfg_reg.period <= period_round; // RL7
         end
         if (addr == `NIM_OFS_WIDTH) begin
            cfg_reg.width <= wr_data;
         end
      end
   end

   // Stored defaults change only on the store command.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         def_reg.ctrl <= `NIM_RST_CTRL;
         def_reg.period <= `NIM_RST_PERIOD;
         def_reg.width <= `NIM_RST_WIDTH;
      end else if (wr_cmd && wr_data[`NIM_CMD_STORE]) begin
         def_reg <= cfg_reg; // RL11
      end
   end

   // Event counter on input 1; a held clear level overrides counting.
   // The pin clear is a synchronised level, so input 2 must stay high for one full clock
   // period to be seen; in exchange no flop has a reset driven from a pin.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt1_reg <= '0;
      end else if (wr_cmd && wr_data[`NIM_CMD_CLR1]) begin
         cnt1_reg <= '0; // RL5
      end else if (cfg_reg.ctrl[`NIM_CTRL_C1_RSTEN] && pins.nim_in[1]) begin
         cnt1_reg <= '0; // RL3
      end else if (cfg_reg.ctrl[`NIM_CTRL_C1_EN] &&
                   edge_hit(pins_prev.nim_in[0], pins.nim_in[0],
                            cfg_reg.ctrl[`NIM_CTRL_C1_RISE])) begin // RL1 RL2
         cnt1_reg <= cnt1_reg + 1'b1; // RL16
      end
   end

   // Event counter on input 3, cleared by input 4.
   // Priorities as for counter 1: software clear, then pin clear, then counting.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt2_reg <= '0;
      end else if (wr_cmd && wr_data[`NIM_CMD_CLR2]) begin
         cnt2_reg <= '0; // RL5
      end else if (cfg_reg.ctrl[`NIM_CTRL_C2_RSTEN] && pins.nim_in[3]) begin
         cnt2_reg <= '0; // RL4
      end else if (cfg_reg.ctrl[`NIM_CTRL_C2_EN] &&
                   edge_hit(pins_prev.nim_in[2], pins.nim_in[2],
                            cfg_reg.ctrl[`NIM_CTRL_C2_RISE])) begin // RL1 RL2
         cnt2_reg <= cnt2_reg + 1'b1; // RL16
      end
   end

   // Pulse generator; a zero period keeps output 1 at its idle level.
   // The phase counter is held at zero while the generator is off, so the first
   // pulse after enabling starts at a known phase.
   assign pg_active = cfg_reg.ctrl[`NIM_CTRL_PG_EN] && (cfg_reg.period != 32'h00000000);
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pg_cnt_reg <= 32'h00000000;
         nim_out1 <= 1'b0;
      end else if (!pg_active) begin
         pg_cnt_reg <= 32'h00000000;
         nim_out1 <= cfg_reg.ctrl[`NIM_CTRL_PG_POL];
      end else begin
         pg_cnt_reg <= (pg_cnt_reg >= cfg_reg.period - 32'h00000001) ? 32'h00000000 :
                       pg_cnt_reg + 32'h00000001; // RL6
         nim_out1 <= (pg_cnt_reg < cfg_reg.width) ^ cfg_reg.ctrl[`NIM_CTRL_PG_POL]; // RL6
      end
   end

   // Coincidence inputs: a rising edge while armed fires, then the dead time counter runs.
   // The dead time count saturates rather than wraps, so a late read never shows a
   // small value that looks like a short dead time.
   generate
      for (gi = 0; gi < 2; gi++) begin : g_combo
         assign trig_hit[gi] = armed_reg[gi] && pins.combo[gi] && !pins_prev.combo[gi];
         assign dt_full[gi] = !armed_reg[gi] && (dt_reg[gi] == {DT_W{1'b1}} - 1'b1);
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               armed_reg[gi] <= 1'b1;
               dt_reg[gi] <= '0;
            end else if (wr_cmd && wr_data[`NIM_CMD_REARM1 + gi]) begin
               armed_reg[gi] <= 1'b1; // RL8
               dt_reg[gi] <= '0;
            end else if (trig_hit[gi]) begin
               armed_reg[gi] <= 1'b0;
            end else if (!armed_reg[gi] && dt_reg[gi] != {DT_W{1'b1}}) begin
               dt_reg[gi] <= dt_reg[gi] + 1'b1; // RL9
            end
         end
      end
   endgenerate

   // Interrupt events in the pending-mask layout.
   assign irq_set = {defbtn_hit, dt_full, trig_hit}; // RL13 RL14

   // Sticky status, write one to clear; a new event in the clearing cycle survives.
   // Masked events still latch, so software can poll the status with the output off.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq_stat_reg <= '0;
      end else if (wr_en && addr == `NIM_OFS_IRQ_STAT) begin
         irq_stat_reg <= (irq_stat_reg & ~wr_data[`NIM_IRQ_W-1:0]) | irq_set;
      end else begin
         irq_stat_reg <= irq_stat_reg | irq_set;
      end
   end

   // Interrupt mask, one enables the matching status bit.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq_mask_reg <= '0;
      end else if (wr_en && addr == `NIM_OFS_IRQ_MASK) begin
         irq_mask_reg <= wr_data[`NIM_IRQ_W-1:0];
      end
   end

   // Level interrupt output, one cycle behind the status.
   // The extra cycle keeps the output straight from a flip-flop.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // Read data stand only in the cycle after the read strobe; unmapped reads give zero.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rd_data <= 32'h00000000;
      end else if (!rd_en) begin
         rd_data <= 32'h00000000;
      end else begin
         unique case (addr)
            `NIM_OFS_CTRL: rd_data <= {24'h000000, cfg_reg.ctrl};
            `NIM_OFS_CNT1: rd_data <= 32'(cnt1_reg);
            `NIM_OFS_CNT2: rd_data <= 32'(cnt2_reg);
            `NIM_OFS_PERIOD: rd_data <= cfg_reg.period;
            `NIM_OFS_WIDTH: rd_data <= cfg_reg.width;
            `NIM_OFS_DT1: rd_data <= 32'(dt_reg[0]); // RL9
            `NIM_OFS_DT2: rd_data <= 32'(dt_reg[1]); // RL9
            `NIM_OFS_IRQ_STAT: rd_data <= 32'(irq_stat_reg); // RL13
            `NIM_OFS_IRQ_MASK: rd_data <= 32'(irq_mask_reg);
            `NIM_OFS_STATUS: rd_data <= {30'h0, armed_reg};
            default: rd_data <= 32'h00000000;
         endcase
      end
   end

endmodule // nim_io

// ---- core/nim_io_consts.svh ----
// Register offsets, field positions and reset values of the NIM I/O block.
`ifndef NIM_IO_CONSTS_SVH
`define NIM_IO_CONSTS_SVH
`define NIM_OFS_CTRL 8'h00
`define NIM_OFS_CMD 8'h04
`define NIM_OFS_CNT1 8'h08
`define NIM_OFS_CNT2 8'h0C
`define NIM_OFS_PERIOD 8'h10
`define NIM_OFS_WIDTH 8'h14
`define NIM_OFS_DT1 8'h18
`define NIM_OFS_DT2 8'h1C
`define NIM_OFS_IRQ_STAT 8'h20
`define NIM_OFS_IRQ_MASK 8'h24
`define NIM_OFS_STATUS 8'h28
// Control register fields.
`define NIM_CTRL_C1_EN 0
`define NIM_CTRL_C1_RISE 1
`define NIM_CTRL_C1_RSTEN 2
`define NIM_CTRL_C2_EN 3
`define NIM_CTRL_C2_RISE 4
`define NIM_CTRL_C2_RSTEN 5
`define NIM_CTRL_PG_EN 6
`define NIM_CTRL_PG_POL 7
// Command register fields, each a one-cycle action.
`define NIM_CMD_CLR1 0
`define NIM_CMD_CLR2 1
`define NIM_CMD_REARM1 2
`define NIM_CMD_REARM2 3
`define NIM_CMD_STORE 4
// Interrupt status and mask fields.
`define NIM_IRQ_TRIG1 0
`define NIM_IRQ_TRIG2 1
`define NIM_IRQ_DTC1 2
`define NIM_IRQ_DTC2 3
`define NIM_IRQ_DEFBTN 4
`define NIM_IRQ_W 5
// Reset values of the active and stored default configuration.
`define NIM_RST_CTRL 8'h00
`define NIM_RST_PERIOD 32'h00000000
`define NIM_RST_WIDTH 32'h00000000
`endif

// ---- core/nim_io_pkg.sv ----
// Types shared by the NIM I/O block.
package nim_io_pkg;
   // One complete I/O configuration, active or stored as default.
   typedef struct packed {
      logic [7:0] ctrl;
      logic [31:0] period;
      logic [31:0] width;
   } cfg_s;
   // Front-panel pins after synchronisation.
   typedef struct packed {
      logic [3:0] nim_in;
      logic [1:0] combo;
      logic default_btn;
      logic reset_btn;
      logic reset_sw;
   } pins_s;
endpackage

// ---- verification/nim_io_monitor.sv ----
// Port-level checks for the NIM I/O block.
`timescale 1ns/10ps
`include "nim_io_consts.svh"
module nim_io_monitor (
   // Clock, reset and register port.
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic rd_en,
   input wire logic wr_en,
   input wire logic [31:0] wr_data,
   input wire logic [31:0] rd_data,
   // Pins and outputs.
   input wire logic reset_btn,
   input wire logic reset_sw,
   input wire logic nim_out1,
   input wire logic irq,
   input wire logic hw_reset
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // The pin needs four sampled edges to clear both sync stages and the output flop.
   sequence pin_closed;
      (reset_btn || reset_sw) [*4];
   endsequence
   sequence pin_open;
      !(reset_btn || reset_sw) [*4];
   endsequence
   chk_hwrst_closed: assert property (pin_closed |-> hw_reset)
      else $error("hw_reset low with reset pin held");
   chk_hwrst_open: assert property (pin_open |-> !hw_reset)
      else $error("hw_reset high with reset pins open");
   chk_period_round: assert property (rd_en && addr == `NIM_OFS_PERIOD |=> rd_data[2:0] == 3'h0)
      else $error("period not on resolution step");
   chk_irq_width: assert property (rd_en && (addr == `NIM_OFS_IRQ_STAT ||
      addr == `NIM_OFS_IRQ_MASK) |=> rd_data[31:5] == 27'h0)
      else $error("interrupt register upper bits set");
   chk_armed_width: assert property (rd_en && addr == `NIM_OFS_STATUS |=> rd_data[31:2] == 30'h0)
      else $error("status upper bits set");
   chk_irq_masked: assert property (wr_en && addr == `NIM_OFS_IRQ_MASK &&
      wr_data[4:0] == 5'h0 |=> ##1 !irq)
      else $error("irq high with all sources masked");
   chk_rd_idle: assert property (!rd_en |=> rd_data == 32'h0)
      else $error("read data not zero outside read");
   chk_cmd_unmapped: assert property (rd_en && (addr == `NIM_OFS_CMD || addr == 8'h30)
      |=> rd_data == 32'h0)
      else $error("command or unmapped read not zero");
   chk_reset_quiet: assert property ($fell(rst) |-> !irq && !hw_reset && !nim_out1)
      else $error("outputs active after reset");
endmodule // nim_io_monitor

// ---- verification/nim_pins_model.sv ----
// Front-panel signal sources, buttons and reset switch.
`timescale 1ns/10ps
module nim_pins_model (
   // Pacing clock.
   input wire logic ref_clk,
   // Front-panel pins.
   output logic [3:0] nim_in,
   output logic [1:0] combo_in,
   output logic default_btn,
   output logic reset_btn,
   output logic reset_sw
);
   logic [8:0] lvl_reg = 9'h000;
   // All sources idle low; switch closure is a held level.
   assign {reset_btn, reset_sw, default_btn, combo_in, nim_in} = lvl_reg;
   // Moves one source at a clock edge.
   task set_lvl(input int k, input logic v);
      @(posedge ref_clk);
      lvl_reg[k] <= v;
   endtask
   // Pulses stay four cycles each way so no edge is lost in the synchroniser.
   task pulse(input int k, input int n);
      repeat (n) begin
         set_lvl(k, 1'b1);
         repeat (3) @(posedge ref_clk);
         set_lvl(k, 1'b0);
         repeat (3) @(posedge ref_clk);
      end
   endtask
endmodule // nim_pins_model

// ---- verification/tb_top.sv ----
// Self-checking bench for the NIM I/O block.
`timescale 1ns/10ps
`include "nim_io_consts.svh"
module tb_top;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wr_data = 32'h0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [31:0] rd_data;
   logic [3:0] nim_in;
   logic [1:0] combo_in;
   logic default_btn, reset_btn, reset_sw, nim_out1, irq, hw_reset;
   int fails = 0;
   int checked = 0;
   int cycles = 0;
   int hi;
   logic [31:0] pv[4] = '{32'hD, 32'hB, 32'hC, 32'hFFFFFFFF};
   logic [31:0] pe[4] = '{32'h10, 32'h8, 32'h10, 32'hFFFFFFF8};
   logic [7:0] gc[4] = '{8'h40, 8'hC0, 8'h80, 8'h00};
   int ge[4] = '{6, 10, 16, 0};
   // Small count widths let wrap and dead time saturation show quickly.
   nim_io #(.CNT_W(4), .DT_W(4)) DUT (.ref_clk(ref_clk), .rst(rst), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .nim_in(nim_in),
      .combo_in(combo_in), .default_btn(default_btn), .reset_btn(reset_btn),
      .reset_sw(reset_sw), .nim_out1(nim_out1), .irq(irq), .hw_reset(hw_reset));
   nim_pins_model PIN (.ref_clk(ref_clk), .nim_in(nim_in), .combo_in(combo_in),
      .default_btn(default_btn), .reset_btn(reset_btn), .reset_sw(reset_sw));
   // Free-running clock.
   always #2 ref_clk = ~ref_clk;
   // A hung test counts as a mismatch.
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         test_done();
      end
   end
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
      @(posedge ref_clk);
   endtask
   // Read data stands only in the cycle after the strobe.
   task rd(input logic [7:0] a, input logic [31:0] e);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1 cmp(rd_data, e);
      @(posedge ref_clk);
   endtask
   task test_done;
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Main sequence.
   initial begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rd(`NIM_OFS_CTRL, {24'h0, `NIM_RST_CTRL});
      rd(`NIM_OFS_PERIOD, `NIM_RST_PERIOD);
      rd(`NIM_OFS_STATUS, 32'h3);
      wr(`NIM_OFS_CTRL, 32'h03);
      PIN.pulse(0, 16);
      PIN.pulse(2, 2);
      rd(`NIM_OFS_CNT1, 32'h0);
      rd(`NIM_OFS_CNT2, 32'h0);
      PIN.set_lvl(0, 1'b1);
      repeat (4) @(posedge ref_clk);
      rd(`NIM_OFS_CNT1, 32'h1);
      wr(`NIM_OFS_CTRL, 32'h08);
      PIN.set_lvl(0, 1'b0);
      PIN.set_lvl(2, 1'b1);
      repeat (4) @(posedge ref_clk);
      rd(`NIM_OFS_CNT2, 32'h0);
      PIN.set_lvl(2, 1'b0);
      repeat (4) @(posedge ref_clk);
      rd(`NIM_OFS_CNT2, 32'h1);
      rd(`NIM_OFS_CNT1, 32'h1);
      wr(`NIM_OFS_CTRL, 32'h2D);
      PIN.pulse(1, 1);
      rd(`NIM_OFS_CNT1, 32'h0);
      rd(`NIM_OFS_CNT2, 32'h1);
      PIN.pulse(3, 1);
      rd(`NIM_OFS_CNT2, 32'h0);
      PIN.pulse(0, 2);
      PIN.pulse(2, 1);
      wr(`NIM_OFS_CMD, 32'h1);
      rd(`NIM_OFS_CNT1, 32'h0);
      rd(`NIM_OFS_CNT2, 32'h1);
      wr(`NIM_OFS_CTRL, 32'h19);
      PIN.pulse(2, 1);
      PIN.pulse(0, 1);
      rd(`NIM_OFS_CNT2, 32'h2);
      wr(`NIM_OFS_CMD, 32'h2);
      rd(`NIM_OFS_CNT2, 32'h0);
      rd(`NIM_OFS_CNT1, 32'h1);
      for (int i = 0; i < 4; i++) begin
         wr(`NIM_OFS_PERIOD, pv[i]);
         rd(`NIM_OFS_PERIOD, pe[i]);
      end
      wr(`NIM_OFS_PERIOD, 32'h8);
      wr(`NIM_OFS_WIDTH, 32'h3);
      for (int i = 0; i < 4; i++) begin
         wr(`NIM_OFS_CTRL, {24'h0, gc[i]});
         hi = 0;
         repeat (16) begin
            @(posedge ref_clk);
            #1 if (nim_out1 === 1'b1) hi++;
         end
         @(posedge ref_clk);
         cmp(hi, ge[i]);
      end
      wr(`NIM_OFS_IRQ_MASK, 32'h1F);
      PIN.pulse(4, 1);
      repeat (20) @(posedge ref_clk);
      rd(`NIM_OFS_STATUS, 32'h2);
      rd(`NIM_OFS_DT1, 32'hF);
      rd(`NIM_OFS_DT1, 32'hF);
      cmp({31'h0, irq}, 32'h1);
      wr(`NIM_OFS_CMD, 32'h4);
      rd(`NIM_OFS_DT1, 32'h0);
      PIN.pulse(5, 1);
      repeat (20) @(posedge ref_clk);
      rd(`NIM_OFS_IRQ_STAT, 32'hF);
      wr(`NIM_OFS_CMD, 32'h8);
      rd(`NIM_OFS_STATUS, 32'h3);
      wr(`NIM_OFS_IRQ_MASK, 32'h0);
      wr(`NIM_OFS_IRQ_STAT, 32'h0A);
      rd(`NIM_OFS_IRQ_STAT, 32'h5);
      cmp({31'h0, irq}, 32'h0);
      wr(`NIM_OFS_IRQ_STAT, 32'h1F);
      wr(`NIM_OFS_CTRL, 32'h09);
      wr(`NIM_OFS_WIDTH, 32'h4);
      wr(`NIM_OFS_CMD, 32'h10);
      wr(`NIM_OFS_IRQ_MASK, 32'h10);
      repeat (2) begin
         wr(`NIM_OFS_CTRL, 32'h01);
         PIN.pulse(6, 1);
         rd(`NIM_OFS_CTRL, 32'h09);
         rd(`NIM_OFS_WIDTH, 32'h4);
         rd(`NIM_OFS_IRQ_STAT, 32'h10);
         cmp({31'h0, irq}, 32'h1);
         wr(`NIM_OFS_IRQ_STAT, 32'h10);
      end
      wr(8'h30, 32'h5A);
      rd(8'h30, 32'h0);
      rd(`NIM_OFS_CMD, 32'h0);
      for (int k = 7; k < 9; k++) begin
         PIN.set_lvl(k, 1'b1);
         repeat (4) @(posedge ref_clk);
         cmp({31'h0, hw_reset}, 32'h1);
         PIN.set_lvl(k, 1'b0);
         repeat (4) @(posedge ref_clk);
         cmp({31'h0, hw_reset}, 32'h0);
      end
      test_done();
   end
endmodule // tb_top
bind nim_io nim_io_monitor MON (.ref_clk(ref_clk), .rst(rst), .addr(addr), .rd_en(rd_en),
   .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data), .reset_btn(reset_btn),
   .reset_sw(reset_sw), .nim_out1(nim_out1), .irq(irq), .hw_reset(hw_reset));
